// >>> core/cmc_muting_ctrl.sv
// Conveyor muting controller for a safety light curtain
//
// Function
// - Total muting time is off (zero) or 5 to 3600 s in 1 s steps.
// - Simultaneity window is off or 10 to 3000 ms in 10 ms steps.
// - Gap filter is off or 10 to 1000 ms in 10 ms steps.
// - Extra hold after curtain clears is 0, 200, 500 or 1000 ms.
// - Minimum override pulse is 100 ms or 350 ms.
// - Order checking follows the variant: sequential on, parallel and cross off.
// - Without direction, either sensor pair may start muting.
// - Forward: entry pair first; end when exit pair drops from all four.
// - Backward: exit pair first; end when entry pair drops from all four.
// - All-free start: every sensor low and curtain high before a new sequence.
// - One-free start: all sensors but any one low and curtain high; error recovery still needs all low.
// - Pair end: muting ends when any sensor of last pair goes low.
// - Safety-device end: muting ends when curtain outputs return high.
// - Curtain low after muting end drops release until end condition holds.
// - Total time exceeded raises muting error and error flag, drops release.
// - Total timer starts with muting status and clears when muting ends.
// - Belt-stopped input pauses the total timer while high.
// - Extra hold only with safety-device end, counted from curtain return.
// - Simultaneity timer starts on sensor change; pair mismatch at expiry errors.
// - Short gap on one sensor per pair is treated as continuous high.
// - A second concurrent gap on another sensor ends muting at once.
// - With order checking, any wrong activation order raises muting error.
`timescale 1ns/1ps
module cmc_muting_ctrl #(
   parameter int TICK_CYCLES = cmc_pkg::TICK_CYCLES_DFLT
) (
   clk_sys,
   srst,
   cfg,
   sensorPins,
   curtainSafeOutput,
   beltStopped,
   stat,
   seqCheckActive,
   ovrMinPulseMs
);
   import cmc_pkg::*;

   input wire logic clk_sys;
   input wire logic srst;
   input wire cmc_pkg::cmc_cfg_t cfg;
   input wire cmc_pkg::cmc_sens_t sensorPins;
   input wire logic curtainSafeOutput;
   input wire logic beltStopped;
   output cmc_pkg::cmc_stat_t stat;
   output logic seqCheckActive;
   output logic [8:0] ovrMinPulseMs;

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [5:0] syncA_q;
   logic [5:0] syncB_q;
   logic [3:0] raw;
   logic curtain;
   logic belt;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         syncA_q <= 6'h00;
         syncB_q <= 6'h00;
      end else begin
         syncA_q <= {beltStopped, curtainSafeOutput, sensorPins};
         syncB_q <= syncA_q;
      end
   end

   assign raw = syncB_q[3:0];
   assign curtain = syncB_q[4];
   assign belt = syncB_q[5];

   // ****************************************
   // Logic tick
   // ****************************************
   logic [16:0] preCnt_q;
   logic tick;

   assign tick = (preCnt_q == 17'(TICK_CYCLES - 1));

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         preCnt_q <= 17'h00000;
      end else if (tick) begin
         preCnt_q <= 17'h00000;
      end else begin
         preCnt_q <= preCnt_q + 17'h00001;
      end
   end

   // ****************************************
   // Configured limits
   // ****************************************
   logic [11:0] totalLim;
   logic [11:0] simulLimMs;
   logic [9:0] gapLimMs;
   logic [9:0] holdMs;
   logic [8:0] simulSteps;
   logic [6:0] gapSteps;
   logic gapEn;
   logic simulEn;
   logic seqEn;

   always_comb begin
      if (cfg.totalSec == 12'h000) begin
         totalLim = 12'h000;
      end else if (cfg.totalSec < TOTAL_MIN_S) begin
         totalLim = TOTAL_MIN_S;
      end else if (cfg.totalSec > TOTAL_MAX_S) begin
         totalLim = TOTAL_MAX_S;
      end else begin
         totalLim = cfg.totalSec;
      end
      simulSteps = (cfg.simulSteps > SIMUL_MAX_STEPS) ? SIMUL_MAX_STEPS : cfg.simulSteps;
      gapSteps = (cfg.gapSteps > GAP_MAX_STEPS) ? GAP_MAX_STEPS : cfg.gapSteps;
      simulLimMs = 12'({3'h0, simulSteps} * STEP_MS);
      gapLimMs = 10'({5'h00, gapSteps} * STEP_MS);
      unique case (cfg.holdSel)
         HOLD_0: holdMs = 10'h000;
         HOLD_200: holdMs = HOLD_200_MS;
         HOLD_500: holdMs = HOLD_500_MS;
         HOLD_1000: holdMs = HOLD_1000_MS;
      endcase
   end

   assign gapEn = (gapSteps != 7'h00);
   assign simulEn = (simulSteps != 9'h000);
   assign seqEn = (cfg.variant == VAR_SEQUENTIAL);

   // ****************************************
   // Gap filter per sensor
   // ****************************************
   logic [3:0] filtHi_q;
   logic [3:0] gapOn;
   logic [3:0] eff;
   logic [9:0] gapCnt_q [4];
   logic gapAbort;

   for (genvar i = 0; i < 4; i++) begin : g_gap
      assign gapOn[i] = gapEn & filtHi_q[i] & ~raw[i] & (gapCnt_q[i] < gapLimMs);
      // Bridge only while the partner of the pair shows no gap
      assign eff[i] = raw[i] | (gapOn[i] & ~gapOn[i ^ 1]);

      always_ff @(posedge clk_sys) begin
         if (srst) begin
            gapCnt_q[i] <= 10'h000;
         end else if (raw[i] || !filtHi_q[i]) begin
            gapCnt_q[i] <= 10'h000;
         end else if (tick && gapCnt_q[i] < gapLimMs) begin
            gapCnt_q[i] <= gapCnt_q[i] + 10'h001;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         filtHi_q <= SENS_RST;
      end else begin
         filtHi_q <= eff;
      end
   end

   assign gapAbort = ({2'h0, gapOn[0]} + {2'h0, gapOn[1]} + {2'h0, gapOn[2]}
                      + {2'h0, gapOn[3]}) > 3'h1;

   // ****************************************
   // Pair status and start condition
   // ****************************************
   logic entryAll;
   logic exitAll;
   logic [2:0] activeCnt;
   logic startReady;
   logic [3:0] rise;

   assign entryAll = eff[0] & eff[1];
   assign exitAll = eff[2] & eff[3];
   assign activeCnt = {2'h0, eff[0]} + {2'h0, eff[1]} + {2'h0, eff[2]} + {2'h0, eff[3]};
   assign startReady = curtain & ((activeCnt == 3'h0)
                       | (cfg.startOneFree & activeCnt <= 3'h1));
   assign rise = eff & ~filtHi_q;

   // ****************************************
   // Order checking
   // ****************************************
   function automatic logic orderOk(input logic [3:0] v, input int idx, input logic rev);
      logic ok;
      ok = 1'b1;
      for (int j = 0; j < 4; j++) begin
         if (j != idx) begin
            if ((j < idx) != rev) begin
               ok = ok & v[j];
            end else begin
               ok = ok & ~v[j];
            end
         end
      end
      return ok;
   endfunction

   logic seqErr;

   always_comb begin
      seqErr = 1'b0;
      for (int i = 0; i < 4; i++) begin
         if (rise[i]) begin
            unique case (cfg.dir)
               DIR_FWD: seqErr = seqErr | ~orderOk(eff, i, 1'b0);
               DIR_BWD: seqErr = seqErr | ~orderOk(eff, i, 1'b1);
               default: seqErr = seqErr | ~(orderOk(eff, i, 1'b0) | orderOk(eff, i, 1'b1));
            endcase
         end
      end
      seqErr = seqErr & seqEn;
   end

   // ****************************************
   // Simultaneity monitor
   // ****************************************
   logic simulRun_q;
   logic [11:0] simulCnt_q;
   logic pairsAgree;
   logic simulErr;

   assign pairsAgree = (eff[0] == eff[1]) & (eff[2] == eff[3]);
   assign simulErr = simulRun_q & ~pairsAgree & (simulCnt_q >= simulLimMs);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         simulRun_q <= 1'b0;
         simulCnt_q <= 12'h000;
      end else if (!simulEn || (simulRun_q && pairsAgree)) begin
         simulRun_q <= 1'b0;
         simulCnt_q <= 12'h000;
      end else if (!simulRun_q) begin
         simulRun_q <= (eff != filtHi_q);
         simulCnt_q <= 12'h000;
      end else if (tick && simulCnt_q < simulLimMs) begin
         simulCnt_q <= simulCnt_q + 12'h001;
      end
   end

   // ****************************************
   // Muting sequence
   // ****************************************
   cmc_state_t state_q;
   cmc_state_t state_d;
   logic firstExit_q;
   logic curtainLow_q;
   logic curtainPrev_q;
   logic lastFull_q;
   logic lastFull;
   logic timeout;
   logic timeoutErr_q;
   logic [9:0] holdCnt_q;
   logic [9:0] msCnt_q;
   logic [11:0] secCnt_q;

   assign lastFull = firstExit_q ? entryAll : exitAll;
   assign timeout = (totalLim != 12'h000) & (secCnt_q >= totalLim);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_ARMED: begin
            if (simulErr || seqErr) begin
               state_d = ST_ERROR;
            end else if (curtain && entryAll && cfg.dir != DIR_BWD) begin
               state_d = ST_MUTING;
            end else if (curtain && exitAll && cfg.dir != DIR_FWD) begin
               state_d = ST_MUTING;
            end else if ((exitAll && cfg.dir == DIR_FWD)
                         || (entryAll && cfg.dir == DIR_BWD)) begin
               // Wrong pair first: refused until all sensors, or all but one with one-free start, are free again
               state_d = ST_WAIT;
            end
         end
         ST_MUTING: begin
            if (timeout || simulErr || seqErr) begin
               state_d = ST_ERROR;
            end else if (gapAbort) begin
               state_d = ST_WAIT;
            end else if (cfg.endBySafety && curtainLow_q && curtain) begin
               state_d = (holdMs == 10'h000) ? ST_WAIT : ST_HOLD;
            end else if (!cfg.endBySafety && lastFull_q && !lastFull) begin
               state_d = ST_WAIT;
            end else if (!entryAll && !exitAll) begin
               state_d = ST_WAIT;
            end
         end
         ST_HOLD: begin
            if (timeout) begin
               state_d = ST_ERROR;
            end else if (holdCnt_q >= holdMs) begin
               state_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (startReady) begin
               state_d = ST_ARMED;
            end
         end
         ST_ERROR: begin
            if (curtain && activeCnt == 3'h0) begin
               state_d = ST_ARMED;
            end
         end
         default: state_d = ST_ERROR;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_q <= ST_WAIT;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         firstExit_q <= 1'b0;
         lastFull_q <= 1'b0;
         curtainLow_q <= 1'b0;
         curtainPrev_q <= 1'b0;
      end else begin
         curtainPrev_q <= curtain;
         if (state_q == ST_ARMED) begin
            firstExit_q <= !(entryAll && cfg.dir != DIR_BWD);
            lastFull_q <= 1'b0;
            curtainLow_q <= 1'b0;
         end else if (state_q == ST_MUTING) begin
            lastFull_q <= lastFull_q | (entryAll & exitAll);
            curtainLow_q <= curtainLow_q | ~curtain;
         end
      end
   end

   // ****************************************
   // Hold and total timers
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         holdCnt_q <= 10'h000;
      end else if (state_q != ST_HOLD) begin
         holdCnt_q <= 10'h000;
      end else if (tick) begin
         holdCnt_q <= holdCnt_q + 10'h001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         msCnt_q <= 10'h000;
         secCnt_q <= 12'h000;
      end else if (state_q != ST_MUTING && state_q != ST_HOLD) begin
         msCnt_q <= 10'h000;
         secCnt_q <= 12'h000;
      end else if (tick && !(cfg.beltUsed && belt) && !timeout) begin
         if (msCnt_q == MS_PER_S - 10'h001) begin
            msCnt_q <= 10'h000;
            secCnt_q <= secCnt_q + 12'h001;
         end else begin
            msCnt_q <= msCnt_q + 10'h001;
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         timeoutErr_q <= 1'b0;
      end else if (state_d != ST_ERROR) begin
         timeoutErr_q <= 1'b0;
      end else if (timeout) begin
         timeoutErr_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         stat <= '0;
         seqCheckActive <= 1'b0;
         ovrMinPulseMs <= OVR_SHORT_MS;
      end else begin
         stat.mutingStatus <= (state_d == ST_MUTING) || (state_d == ST_HOLD);
         stat.releaseOut <= (state_d == ST_MUTING) || (state_d == ST_HOLD)
                         || (curtain && (state_d == ST_ARMED || state_d == ST_WAIT));
         stat.mutingError <= (state_d == ST_ERROR);
         stat.errorFlag <= (state_d == ST_ERROR) && (timeout || timeoutErr_q);
         seqCheckActive <= seqEn;
         ovrMinPulseMs <= cfg.ovrLong ? OVR_LONG_MS : OVR_SHORT_MS;
      end
   end

endmodule

// >>> core/cmc_pkg.sv
// Package with types and constants of the conveyor muting controller
package cmc_pkg;

   // ****************************************
   // Clock and logic tick
   // ****************************************
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES_DFLT = TICK_US * CLK_MHZ;

   // ****************************************
   // Time limits
   // ****************************************
   localparam logic [11:0] TOTAL_MIN_S = 12'h005;
   localparam logic [11:0] TOTAL_MAX_S = 12'hE10;
   localparam logic [9:0] MS_PER_S = 10'h3E8;
   localparam logic [11:0] STEP_MS = 12'h00A;
   localparam logic [8:0] SIMUL_MAX_STEPS = 9'h12C;
   localparam logic [6:0] GAP_MAX_STEPS = 7'h64;
   localparam logic [9:0] HOLD_200_MS = 10'h0C8;
   localparam logic [9:0] HOLD_500_MS = 10'h1F4;
   localparam logic [9:0] HOLD_1000_MS = 10'h3E8;
   localparam logic [8:0] OVR_SHORT_MS = 9'h064;
   localparam logic [8:0] OVR_LONG_MS = 9'h15E;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [3:0] SENS_RST = 4'h0;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {DIR_NONE = 2'h0, DIR_FWD = 2'h1, DIR_BWD = 2'h2} cmc_dir_t;
   typedef enum logic [1:0] {
      VAR_PARALLEL = 2'h0,
      VAR_SEQUENTIAL = 2'h1,
      VAR_CROSS = 2'h2
   } cmc_var_t;
   typedef enum logic [1:0] {
      HOLD_0 = 2'h0,
      HOLD_200 = 2'h1,
      HOLD_500 = 2'h2,
      HOLD_1000 = 2'h3
   } cmc_hold_t;
   typedef enum logic [2:0] {
      ST_ARMED = 3'h0,
      ST_MUTING = 3'h1,
      ST_HOLD = 3'h3,
      ST_WAIT = 3'h2,
      ST_ERROR = 3'h6
   } cmc_state_t;

   typedef struct packed {
      logic exitSensorSecond;
      logic exitSensorFirst;
      logic entrySensorSecond;
      logic entrySensorFirst;
   } cmc_sens_t;

   typedef struct packed {
      cmc_dir_t dir;
      cmc_var_t variant;
      logic startOneFree;
      logic endBySafety;
      logic beltUsed;
      logic [11:0] totalSec;
      logic [8:0] simulSteps;
      logic [6:0] gapSteps;
      cmc_hold_t holdSel;
      logic ovrLong;
   } cmc_cfg_t;

   typedef struct packed {
      logic releaseOut;
      logic mutingStatus;
      logic mutingError;
      logic errorFlag;
   } cmc_stat_t;

endpackage

// >>> testbench/cmc_conveyor_model.sv
// Behavioural conveyor carrying one object past four muting sensors and a curtain
`timescale 1ns/1ps
module cmc_conveyor_model (
   input wire logic [3:0] pos,
   input wire logic backward,
   input wire logic [3:0] addMask,
   input wire logic [3:0] dropMask,
   input wire logic curtainBreak,
   output cmc_pkg::cmc_sens_t sensorPins,
   output logic curtainSafeOutput
);
   import cmc_pkg::*;
   logic [3:0] fill;
   logic [3:0] pins;
   // ****
   // Object position to sensor pattern; the curtain sits between the pairs
   // ****
   always_comb begin
      fill = (pos <= 4'h4) ? 4'((5'h01 << pos) - 5'h01) : 4'(4'hF << (pos - 4'h4));
      pins = backward ? {fill[0], fill[1], fill[2], fill[3]} : fill;
      sensorPins = (pins | addMask) & ~dropMask;
      curtainSafeOutput = !curtainBreak && !(pos >= 4'h3 && pos <= 4'h5);
   end
endmodule

// >>> testbench/cmc_muting_ctrl_sva.sv
// Checker of the conveyor muting controller outputs
`timescale 1ns/1ps
module cmc_muting_ctrl_sva #(
   parameter int TICK_CYCLES = 10
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire cmc_pkg::cmc_cfg_t cfg,
   input wire cmc_pkg::cmc_sens_t sensorPins,
   input wire logic curtainSafeOutput,
   input wire logic beltStopped,
   input wire cmc_pkg::cmc_stat_t stat,
   input wire logic seqCheckActive,
   input wire logic [8:0] ovrMinPulseMs
);
   import cmc_pkg::*;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   // ****
   // Assertions and cover points
   // ****
   seq_flag_a: assert property (!$past(srst) && !$past(srst, 2) |->
      seqCheckActive == (cfg.variant == VAR_SEQUENTIAL)) else $error("order flag wrong");
   ovr_pulse_a: assert property (!$past(srst) && !$past(srst, 2) |->
      ovrMinPulseMs == (cfg.ovrLong ? 9'h15E : 9'h064)) else $error("override pulse wrong");
   err_flag_a: assert property (stat.errorFlag |->
      stat.mutingError && !stat.releaseOut) else $error("flag without error");
   error_quiet_a: assert property (stat.mutingError |->
      !stat.releaseOut && !stat.mutingStatus) else $error("error with release");
   mute_release_a: assert property (stat.mutingStatus |-> stat.releaseOut)
      else $error("muting without release");
   start_pair_a: assert property ($rose(stat.mutingStatus) |->
      (&$past(sensorPins[1:0], 3)) || (&$past(sensorPins[3:2], 3))) else $error("start no pair");
   fwd_entry_a: assert property ($rose(stat.mutingStatus) && cfg.dir == DIR_FWD |->
      &$past(sensorPins[1:0], 3)) else $error("forward start without entry pair");
   bwd_exit_a: assert property ($rose(stat.mutingStatus) && cfg.dir == DIR_BWD |->
      &$past(sensorPins[3:2], 3)) else $error("backward start without exit pair");
   pair_end_a: assert property ($fell(stat.mutingStatus) && !stat.mutingError &&
      !cfg.endBySafety |-> !(&$past(sensorPins, 3))) else $error("end with all sensors");
   idle_release_a: assert property (!stat.mutingStatus && stat.releaseOut |->
      $past(curtainSafeOutput, 3)) else $error("release with curtain broken");
   mute_seen_c: cover property ($rose(stat.mutingStatus));
   total_err_c: cover property ($rose(stat.errorFlag));
   belt_pause_c: cover property (stat.mutingStatus && beltStopped);
endmodule
bind cmc_muting_ctrl cmc_muting_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) i_sva (
   .clk_sys(clk_sys), .srst(srst), .cfg(cfg), .sensorPins(sensorPins),
   .curtainSafeOutput(curtainSafeOutput), .beltStopped(beltStopped), .stat(stat),
   .seqCheckActive(seqCheckActive), .ovrMinPulseMs(ovrMinPulseMs));

// >>> testbench/cmc_muting_ctrl_tb_top.sv
// Self-checking testbench of the conveyor muting controller
`timescale 1ns/1ps
module cmc_muting_ctrl_tb_top;
   import cmc_pkg::*;
   typedef struct packed {
      cmc_dir_t dir;
      cmc_var_t variant;
      logic safeEnd;
      logic back;
      logic ovrLong;
      logic [8:0] expMask;
   } cmc_row_t;
   localparam cmc_row_t ROWS [8] = '{
      '{DIR_NONE, VAR_PARALLEL, 1'b0, 1'b0, 1'b0, 9'h07C},
      '{DIR_NONE, VAR_PARALLEL, 1'b0, 1'b1, 1'b1, 9'h07C},
      '{DIR_FWD, VAR_PARALLEL, 1'b0, 1'b0, 1'b0, 9'h07C},
      '{DIR_FWD, VAR_PARALLEL, 1'b0, 1'b1, 1'b1, 9'h000},
      '{DIR_BWD, VAR_SEQUENTIAL, 1'b0, 1'b1, 1'b0, 9'h07C},
      '{DIR_BWD, VAR_PARALLEL, 1'b0, 1'b0, 1'b1, 9'h000},
      '{DIR_NONE, VAR_SEQUENTIAL, 1'b0, 1'b0, 1'b1, 9'h07C},
      '{DIR_NONE, VAR_CROSS, 1'b1, 1'b0, 1'b0, 9'h03C}};
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   cmc_cfg_t cfg;
   cmc_cfg_t c;
   cmc_sens_t sensorPins;
   logic curtainSafeOutput;
   logic beltStopped = 1'b0;
   cmc_stat_t stat;
   logic seqCheckActive;
   logic [8:0] ovrMinPulseMs;
   logic [8:0] seen;
   logic [3:0] pos = 4'h0;
   logic backward = 1'b0;
   logic [3:0] addMask = 4'h0;
   logic [3:0] dropMask = 4'h0;
   logic curtainBreak = 1'b0;
   int error_cnt = 0;
   int check_count = 0;

   cmc_muting_ctrl #(.TICK_CYCLES(10)) i_dut (.clk_sys(clk_sys), .srst(srst), .cfg(cfg),
      .sensorPins(sensorPins), .curtainSafeOutput(curtainSafeOutput),
      .beltStopped(beltStopped), .stat(stat), .seqCheckActive(seqCheckActive),
      .ovrMinPulseMs(ovrMinPulseMs));
   cmc_conveyor_model i_belt (.pos(pos), .backward(backward), .addMask(addMask),
      .dropMask(dropMask), .curtainBreak(curtainBreak), .sensorPins(sensorPins),
      .curtainSafeOutput(curtainSafeOutput));

   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   // ****
   // Helpers
   // ****
   task automatic chk_bit(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_word(input string what, input logic [8:0] exp, input logic [8:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   function automatic cmc_cfg_t mk(input cmc_dir_t d, input cmc_var_t v, input logic safeEnd);
      mk = '0;
      mk.dir = d;
      mk.variant = v;
      mk.endBySafety = safeEnd;
   endfunction
   task automatic restart(input cmc_cfg_t nc);
      @(negedge clk_sys);
      srst = 1'b1;
      cfg = nc;
      {pos, addMask, dropMask, curtainBreak, backward} = '0;
      cyc(3);
      srst = 1'b0;
      cyc(5);
   endtask
   task automatic walk(input int last);
      seen = '0;
      for (int p = 0; p <= last; p++) begin
         pos = 4'(p);
         cyc(20);
         seen[p] = stat.mutingStatus;
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #900000;
      error_cnt++;
      $display("watchdog expired");
      tally_and_finish();
   end
   // ****
   // Main sequence
   // ****
   initial begin
      cfg = mk(DIR_NONE, VAR_SEQUENTIAL, 1'b0);
      cfg.ovrLong = 1'b1;
      cyc(3);
      chk_word("stat in reset", 9'h000, 9'(stat));
      chk_bit("order flag in reset", 1'b0, seqCheckActive);
      chk_word("override in reset", OVR_SHORT_MS, ovrMinPulseMs);
      foreach (ROWS[i]) begin
         c = mk(ROWS[i].dir, ROWS[i].variant, ROWS[i].safeEnd);
         c.ovrLong = ROWS[i].ovrLong;
         restart(c);
         backward = ROWS[i].back;
         walk(8);
         chk_word("mute by position", ROWS[i].expMask, seen);
         chk_bit("order flag", ROWS[i].variant == VAR_SEQUENTIAL, seqCheckActive);
         chk_word("override", c.ovrLong ? OVR_LONG_MS : OVR_SHORT_MS, ovrMinPulseMs);
         chk_bit("release idle", 1'b1, stat.releaseOut);
         curtainBreak = 1'b1;
         cyc(5);
         chk_bit("release curtain broken", 1'b0, stat.releaseOut);
         $display("row %0d done", i);
      end
      for (int f = 0; f < 2; f++) begin
         c = mk(DIR_NONE, VAR_PARALLEL, 1'b0);
         c.startOneFree = f[0];
         restart(c);
         walk(7);
         addMask = 4'h3;
         cyc(20);
         chk_bit("start with one sensor left", f[0], stat.mutingStatus);
      end
      $display("start condition done");
      c = mk(DIR_NONE, VAR_PARALLEL, 1'b1);
      c.holdSel = HOLD_200;
      restart(c);
      walk(6);
      cyc(1850);
      chk_bit("hold running", 1'b1, stat.mutingStatus);
      cyc(200);
      chk_bit("hold over", 1'b0, stat.mutingStatus);
      $display("hold done");
      c = mk(DIR_NONE, VAR_PARALLEL, 1'b0);
      c.simulSteps = 9'h001;
      restart(c);
      pos = 4'h1;
      cyc(80);
      chk_bit("mismatch early", 1'b0, stat.mutingError);
      cyc(40);
      chk_bit("mismatch late", 1'b1, stat.mutingError);
      chk_bit("mismatch flag", 1'b0, stat.errorFlag);
      $display("simultaneity done");
      c = mk(DIR_NONE, VAR_PARALLEL, 1'b0);
      c.gapSteps = 7'h02;
      restart(c);
      walk(4);
      dropMask = 4'h1;
      cyc(100);
      chk_bit("single gap bridged", 1'b1, stat.mutingStatus);
      dropMask = 4'h5;
      cyc(10);
      chk_bit("second gap ends", 1'b0, stat.mutingStatus);
      $display("gap done");
      for (int k = 0; k < 2; k++) begin
         restart(mk(DIR_NONE, k ? VAR_SEQUENTIAL : VAR_PARALLEL, 1'b0));
         addMask = 4'h2;
         cyc(20);
         chk_bit("wrong order", k[0], stat.mutingError);
      end
      $display("order done");
      c = mk(DIR_NONE, VAR_PARALLEL, 1'b0);
      c.totalSec = 12'h005;
      c.beltUsed = 1'b1;
      restart(c);
      beltStopped = 1'b1;
      walk(2);
      cyc(5000);
      beltStopped = 1'b0;
      pos = 4'h4;
      cyc(49800);
      chk_bit("total time early", 1'b0, stat.mutingError);
      cyc(400);
      chk_bit("total time error", 1'b1, stat.mutingError);
      chk_bit("total time flag", 1'b1, stat.errorFlag);
      chk_bit("total time release", 1'b0, stat.releaseOut);
      $display("total time done");
      tally_and_finish();
   end
endmodule
